// *** verilog/letc_top.sv ***
// apb registers and line exposure sequencer for a line-scan sensor
// assumes pins are asynchronous; pclk at 20 MHz
//
// Design decisions made here: register access over APB and the register addresses.
`default_nettype none
module letc_top (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        encoder_input_a,
  input  wire logic        external_input_a,
  input  wire logic        external_input_b,
  input  wire logic        external_input_c,
  output logic             line_exposure_begin,
  output logic             exposure_active
);
  letc_trig_if tif ();

  logic [31:0] ctrl_r, ctrl_nxt, prdata_r, prdata_nxt;
  logic [15:0] exp_r, exp_nxt, lper_r, lper_nxt;
  logic        setup, wr, mapped;

  // ---------------------------------------------
  // apb slave, zero wait states
  // ---------------------------------------------
  function automatic logic [15:0] clamp_exp(input logic [15:0] v);
    if (v < letc_pkg::EXP_MIN) return letc_pkg::EXP_MIN;
    else if (v > letc_pkg::EXP_MAX) return letc_pkg::EXP_MAX;
    else return v;
  endfunction : clamp_exp

  assign setup   = psel & ~penable;
  assign wr      = psel & penable & pwrite;
  assign mapped  = (paddr == letc_pkg::ADDR_CTRL) || (paddr == letc_pkg::ADDR_EXPTIME) ||
                   (paddr == letc_pkg::ADDR_LINEPER) || (paddr == letc_pkg::ADDR_STATUS);
  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~mapped;
  assign prdata  = prdata_r;

  letc_pkg::letc_state_t st_r, st_nxt;
  logic [16:0] cnt_r, cnt_nxt;
  logic [15:0] tick_r, tick_nxt;
  logic        int_tick, start, ext_on, width_mode, begin_r, begin_nxt;

  always_comb begin
    ctrl_nxt   = ctrl_r;
    exp_nxt    = exp_r;
    lper_nxt   = lper_r;
    prdata_nxt = prdata_r;
    if (wr && paddr == letc_pkg::ADDR_CTRL) begin
      ctrl_nxt = pwdata & 32'h0000_0777;
    end
    if (wr && paddr == letc_pkg::ADDR_EXPTIME) begin
      exp_nxt = clamp_exp(pwdata[15:0]);
    end
    if (wr && paddr == letc_pkg::ADDR_LINEPER) begin
      lper_nxt = (pwdata[15:0] < letc_pkg::LINEPER_MIN) ? letc_pkg::LINEPER_MIN : pwdata[15:0];
    end
    if (setup && !pwrite) begin
      unique case (paddr)
        letc_pkg::ADDR_CTRL:    prdata_nxt = ctrl_r;
        letc_pkg::ADDR_EXPTIME: prdata_nxt = {16'h0000, exp_r};
        letc_pkg::ADDR_LINEPER: prdata_nxt = {16'h0000, lper_r};
        letc_pkg::ADDR_STATUS:  prdata_nxt = {28'h0000000, tif.lvl, 1'b0, st_r};
        default:                prdata_nxt = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_r   <= letc_pkg::CTRL_RESET;
      exp_r    <= letc_pkg::EXP_RESET;
      lper_r   <= letc_pkg::LINEPER_RESET;
      prdata_r <= 32'h0000_0000;
    end else begin
      ctrl_r   <= ctrl_nxt;
      exp_r    <= exp_nxt;
      lper_r   <= lper_nxt;
      prdata_r <= prdata_nxt;
    end
  end

  // ---------------------------------------------
  // trigger qualification
  // ---------------------------------------------
  assign tif.origin = letc_pkg::letc_origin_t'(ctrl_r[letc_pkg::CTRL_ORG_LSB +: 3]);
  assign tif.act    = letc_pkg::letc_act_t'(ctrl_r[letc_pkg::CTRL_ACT_LSB +: 3]);

  letc_qual u_qual (
    .pclk    (pclk),
    .presetn (presetn),
    .pins    ({external_input_c, external_input_b, external_input_a, encoder_input_a}),
    .tif     (tif)
  );

  // ---------------------------------------------
  // exposure sequencer
  // ---------------------------------------------
  // only the line-start target is wired; the other target value leaves lines internal
  assign ext_on     = ctrl_r[letc_pkg::CTRL_EN_BIT] & ~ctrl_r[letc_pkg::CTRL_TGT_BIT];
  assign width_mode = ext_on & ctrl_r[letc_pkg::CTRL_LEN_BIT];
  assign int_tick   = (tick_r == 16'h0000);
  // events during an exposure are dropped rather than queued
  assign start      = (st_r == letc_pkg::ST_IDLE) && (ext_on ? tif.evt : int_tick);

  always_comb begin
    st_nxt    = st_r;
    cnt_nxt   = cnt_r;
    begin_nxt = start;
    tick_nxt  = (int_tick || ext_on) ? lper_r - 16'h0001 : tick_r - 16'h0001;
    unique case (st_r)
      letc_pkg::ST_IDLE: begin
        if (start && width_mode) begin
          st_nxt = letc_pkg::ST_WIDTH;
        end else if (start) begin
          st_nxt  = letc_pkg::ST_TIMED;
          cnt_nxt = 17'({1'b0, exp_r} * 17'(letc_pkg::CYC_PER_UNIT)) - 17'h00001;
        end
      end
      letc_pkg::ST_TIMED: begin
        if (cnt_r == 17'h00000) st_nxt = letc_pkg::ST_IDLE;
        else cnt_nxt = cnt_r - 17'h00001;
      end
      letc_pkg::ST_WIDTH: begin
        if (!tif.lvl) st_nxt = letc_pkg::ST_IDLE;
      end
      default: st_nxt = letc_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r    <= letc_pkg::ST_IDLE;
      cnt_r   <= 17'h00000;
      tick_r  <= 16'h0000;
      begin_r <= 1'b0;
    end else begin
      st_r    <= st_nxt;
      cnt_r   <= cnt_nxt;
      tick_r  <= tick_nxt;
      begin_r <= begin_nxt;
    end
  end

  assign line_exposure_begin = begin_r;
  assign exposure_active     = (st_r != letc_pkg::ST_IDLE);

  // ---------------------------------------------
  // checks
  // ---------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_timed_start;
    (st_r == letc_pkg::ST_IDLE) && start && !width_mode;
  endsequence

  trig_off_ignored_a: assert property ((!ext_on && !int_tick) |=> !line_exposure_begin)
    else $error("line began with trigger off and no internal tick");
  ext_start_a: assert property ((ext_on && st_r == letc_pkg::ST_IDLE && tif.evt) |=> line_exposure_begin)
    else $error("accepted trigger did not start a line");
  busy_drop_a: assert property ((st_r != letc_pkg::ST_IDLE) |=> !line_exposure_begin)
    else $error("line started during an exposure");
  timed_load_a: assert property (s_timed_start |=>
                                 (cnt_r == 17'({1'b0, $past(exp_r)} * 17'(letc_pkg::CYC_PER_UNIT)) - 17'h00001))
    else $error("timed exposure length wrong");
  timed_end_a: assert property ((st_r == letc_pkg::ST_TIMED && cnt_r == 17'h00000) |=> !exposure_active)
    else $error("timed exposure overran");
  exp_range_a: assert property (exp_r >= letc_pkg::EXP_MIN && exp_r <= letc_pkg::EXP_MAX)
    else $error("exposure time out of range");
  width_hold_a: assert property ((st_r == letc_pkg::ST_WIDTH && tif.lvl) |=> exposure_active)
    else $error("width exposure ended while trigger high");
  width_end_a: assert property ((st_r == letc_pkg::ST_WIDTH && !tif.lvl) |=> !exposure_active)
    else $error("width exposure outlived trigger");
  int_line_a: assert property ((!ext_on && st_r == letc_pkg::ST_IDLE && int_tick) |=> line_exposure_begin)
    else $error("internal tick did not start a line");
  single_pulse_a: assert property (line_exposure_begin |=> !line_exposure_begin)
    else $error("line start pulse lasted more than one cycle");
  begin_active_a: assert property (line_exposure_begin |-> exposure_active)
    else $error("line started without an exposure");
  origin_none_a: assert property ((ext_on && tif.origin == letc_pkg::ORG_NONE) |=> !line_exposure_begin)
    else $error("line started with no trigger source");

  sequence s_width_start;
    (st_r == letc_pkg::ST_IDLE) && start && width_mode;
  endsequence

  width_start_a: assert property (s_width_start |=> (st_r == letc_pkg::ST_WIDTH))
    else $error("accepted trigger did not enter width exposure");
  // timer held reloaded while triggering, so internal lines resume a full period after switch-off
  ext_reload_a: assert property (ext_on |=> (tick_r == $past(lper_r) - 16'h0001))
    else $error("line timer not held while trigger enabled");
  int_reload_a: assert property ((!ext_on && int_tick) |=> (tick_r == $past(lper_r) - 16'h0001))
    else $error("line timer did not restart a period");
  lper_floor_a: assert property (lper_r >= letc_pkg::LINEPER_MIN)
    else $error("line period below its floor");

  // ---------------------------------------------
  // register bus checks
  // ---------------------------------------------
  sequence s_exp_write;
    wr && (paddr == letc_pkg::ADDR_EXPTIME);
  endsequence

  exp_clamp_hi_a: assert property ((s_exp_write ##0 (pwdata[15:0] > letc_pkg::EXP_MAX)) |=>
                                   (exp_r == letc_pkg::EXP_MAX))
    else $error("long exposure write not clamped");
  exp_clamp_lo_a: assert property ((s_exp_write ##0 (pwdata[15:0] < letc_pkg::EXP_MIN)) |=>
                                   (exp_r == letc_pkg::EXP_MIN))
    else $error("short exposure write not clamped");
  exp_store_a: assert property ((s_exp_write ##0 (pwdata[15:0] >= letc_pkg::EXP_MIN) &&
                                 (pwdata[15:0] <= letc_pkg::EXP_MAX)) |=>
                                ({16'h0000, exp_r} == ($past(pwdata) & 32'h0000_ffff)))
    else $error("in-range exposure write not stored");
endmodule : letc_top
`default_nettype wire

// *** verilog/letc_pkg.sv ***
// constants and types for the line exposure trigger control
// assumes a 20 MHz pclk and a 32-bit apb register bus
`default_nettype none
package letc_pkg;
  // ---------------------------------------------
  // register map
  // ---------------------------------------------
  localparam logic [7:0]  ADDR_CTRL     = 8'h00;
  localparam logic [7:0]  ADDR_EXPTIME  = 8'h04;
  localparam logic [7:0]  ADDR_LINEPER  = 8'h08;
  localparam logic [7:0]  ADDR_STATUS   = 8'h0c;

  // ---------------------------------------------
  // control fields
  // ---------------------------------------------
  localparam int          CTRL_EN_BIT   = 0;
  localparam int          CTRL_TGT_BIT  = 1;
  localparam int          CTRL_LEN_BIT  = 2;
  localparam int          CTRL_ACT_LSB  = 4;
  localparam int          CTRL_ORG_LSB  = 8;
  localparam logic [31:0] CTRL_RESET    = 32'h0000_0000;

  // ---------------------------------------------
  // exposure time, held in tenths of a microsecond
  // ---------------------------------------------
  localparam logic [15:0] EXP_MIN       = 16'h0014;  // 2.0
  localparam logic [15:0] EXP_MAX       = 16'h821e;  // 3331.0
  localparam logic [15:0] EXP_RESET     = 16'h0064;
  localparam int          EXP_UNIT_NS   = 100;
  localparam int          CLK_PERIOD_NS = 50;
  localparam int          CYC_PER_UNIT  = (EXP_UNIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [15:0] LINEPER_RESET = 16'h1000;
  localparam logic [15:0] LINEPER_MIN   = 16'h0002;

  typedef enum logic [2:0] {
    ORG_NONE  = 3'h0,
    ORG_ENC_A = 3'h1,
    ORG_EXT_A = 3'h2,
    ORG_EXT_B = 3'h3,
    ORG_EXT_C = 3'h4
  } letc_origin_t;

  typedef enum logic [2:0] {
    ACT_RISE = 3'h0,
    ACT_FALL = 3'h1,
    ACT_ANY  = 3'h2,
    ACT_HIGH = 3'h3,
    ACT_LOW  = 3'h4
  } letc_act_t;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'h0,
    ST_TIMED = 2'h1,
    ST_WIDTH = 2'h2
  } letc_state_t;
endpackage : letc_pkg
`default_nettype wire

// *** verilog/letc_trig_if.sv ***
// link between the register block and the trigger qualifier
// assumes both ends share pclk
`default_nettype none
interface letc_trig_if;
  letc_pkg::letc_origin_t origin;
  letc_pkg::letc_act_t    act;
  logic                   evt;
  logic                   lvl;
  modport ctl (output origin, output act, input evt, input lvl);
  modport qual (input origin, input act, output evt, output lvl);
endinterface : letc_trig_if
`default_nettype wire

// *** verilog/letc_qual.sv ***
// synchronises the trigger pins and qualifies the selected one
// assumes pins are asynchronous to pclk
`default_nettype none
module letc_qual (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic [3:0] pins,
  letc_trig_if.qual       tif
);
  logic [3:0] s1_r, s2_r, s3_r, lvl_r, lvl_nxt, prev_r;
  logic       sel, sel_prev;

  // ---------------------------------------------
  // three-stage sync, level taken once stages 2 and 3 agree
  // ---------------------------------------------
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      lvl_nxt[i] = (s2_r[i] == s3_r[i]) ? s3_r[i] : lvl_r[i];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1_r   <= 4'h0;
      s2_r   <= 4'h0;
      s3_r   <= 4'h0;
      lvl_r  <= 4'h0;
      prev_r <= 4'h0;
    end else begin
      s1_r   <= pins;
      s2_r   <= s1_r;
      s3_r   <= s2_r;
      lvl_r  <= lvl_nxt;
      prev_r <= lvl_r;
    end
  end

  // ---------------------------------------------
  // source select and activation
  // ---------------------------------------------
  always_comb begin
    unique case (tif.origin)
      letc_pkg::ORG_NONE:  begin sel = 1'b0;     sel_prev = 1'b0;      end
      letc_pkg::ORG_ENC_A: begin sel = lvl_r[0]; sel_prev = prev_r[0]; end
      letc_pkg::ORG_EXT_A: begin sel = lvl_r[1]; sel_prev = prev_r[1]; end
      letc_pkg::ORG_EXT_B: begin sel = lvl_r[2]; sel_prev = prev_r[2]; end
      letc_pkg::ORG_EXT_C: begin sel = lvl_r[3]; sel_prev = prev_r[3]; end
      default:             begin sel = 1'b0;     sel_prev = 1'b0;      end
    endcase
  end

  assign tif.lvl = sel;
  always_comb begin
    unique case (tif.act)
      letc_pkg::ACT_RISE: tif.evt = sel & ~sel_prev;
      letc_pkg::ACT_FALL: tif.evt = ~sel & sel_prev;
      letc_pkg::ACT_ANY:  tif.evt = sel ^ sel_prev;
      letc_pkg::ACT_HIGH: tif.evt = sel;
      letc_pkg::ACT_LOW:  tif.evt = ~sel & (tif.origin != letc_pkg::ORG_NONE);
      default:            tif.evt = 1'b0;
    endcase
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  rise_edge_a: assert property ((tif.act == letc_pkg::ACT_RISE && tif.evt) |-> (sel && !$past(sel)))
    else $error("rising activation fired without a rising edge");
  fall_edge_a: assert property ((tif.act == letc_pkg::ACT_FALL && tif.evt) |-> (!sel && $past(sel)))
    else $error("falling activation fired without a falling edge");
  no_source_a: assert property ((tif.origin == letc_pkg::ORG_NONE) |-> !tif.evt)
    else $error("event raised with no source selected");
endmodule : letc_qual
`default_nettype wire

// *** testbench/letc_src.sv ***
// model of the external trigger and encoder source
// assumes the bench picks one pin and its level; other pins wander
`default_nettype none
module letc_src (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic [1:0] pick,
  input  wire logic       lvl,
  output logic            enc_a,
  output logic            ext_a,
  output logic            ext_b,
  output logic            ext_c
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] cnt_r;
  logic [3:0] pins;
  // ---------------------------------------------
  // pin drive
  // ---------------------------------------------
  // unpicked pins toggle so a wrong source select shows up as a stray line
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_r <= 4'h0;
      pins  <= 4'h0;
    end else begin
      cnt_r <= cnt_r + 4'h1;
      for (int i = 0; i < 4; i++) pins[i] <= (pick == i[1:0]) ? lvl : cnt_r[3];
    end
  end
  assign {ext_c, ext_b, ext_a, enc_a} = pins;
endmodule : letc_src
`default_nettype wire

// *** testbench/testbench.sv ***
// self-checking bench for the line exposure trigger control
// assumes letc_pkg, letc_trig_if, letc_qual and letc_top are compiled first
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk, presetn, psel, penable, pwrite, lvl;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata;
  logic pready, pslverr, enc_a, ext_a, ext_b, ext_c, line_exposure_begin, exposure_active;
  logic [1:0] pick;
  int fail_count = 0, compares = 0, act_cnt = 0, beg_cnt = 0;
  localparam logic [31:0] EXP_CYC = 32'h14 * letc_pkg::CYC_PER_UNIT;
  letc_top uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .encoder_input_a(enc_a), .external_input_a(ext_a), .external_input_b(ext_b),
    .external_input_c(ext_c), .line_exposure_begin(line_exposure_begin), .exposure_active(exposure_active));
  letc_src src (.pclk(pclk), .presetn(presetn), .pick(pick), .lvl(lvl),
    .enc_a(enc_a), .ext_a(ext_a), .ext_b(ext_b), .ext_c(ext_c));
  initial begin
    pclk = 0;
    forever #25 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    if (exposure_active === 1'b1) act_cnt++;
    if (line_exposure_begin === 1'b1) beg_cnt++;
  end
  // ---------------------------------------------
  // shared tasks
  // ---------------------------------------------
  task chk(input string nm, input logic [31:0] exp, input logic [31:0] seen);
    compares++;
    if (seen !== exp) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task apb(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q, output logic e);
    @(posedge pclk);
    psel <= 1; penable <= 0; pwrite <= wr; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 0; penable <= 0;
  endtask : apb
  task wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic e;
    apb(1'b1, a, d, q, e);
  endtask : wr
  task wait_pulse(input int lim, output logic got, output int n);
    got = 0;
    n = 0;
    while (!got && n < lim) begin
      @(posedge pclk);
      #1 n++;
      if (line_exposure_begin === 1'b1) got = 1;
    end
  endtask : wait_pulse
  // ---------------------------------------------
  // scenarios
  // ---------------------------------------------
  task test_regs;
    logic [31:0] q;
    logic e;
    apb(0, letc_pkg::ADDR_CTRL, 0, q, e);    chk("ctrl reset", letc_pkg::CTRL_RESET, q);
    apb(0, letc_pkg::ADDR_EXPTIME, 0, q, e); chk("exp reset", 32'h64, q);
    apb(0, letc_pkg::ADDR_LINEPER, 0, q, e); chk("lineper reset", 32'h1000, q);
    wr(letc_pkg::ADDR_EXPTIME, 32'hffff);
    apb(0, letc_pkg::ADDR_EXPTIME, 0, q, e); chk("exp max", 32'h821e, q);
    wr(letc_pkg::ADDR_EXPTIME, 32'h0);
    apb(0, letc_pkg::ADDR_EXPTIME, 0, q, e); chk("exp min", 32'h14, q);
    wr(letc_pkg::ADDR_CTRL, 32'hffff_ffff);
    apb(0, letc_pkg::ADDR_CTRL, 0, q, e); chk("ctrl mask", 32'h777, q);
    chk("mapped err", 0, e);
    chk("pready", 1, pready);
    apb(0, 8'h10, 0, q, e);
    chk("unmapped err", 1, e);
    chk("unmapped data", 0, q);
    $display("test_regs done");
  endtask : test_regs
  task test_internal;
    logic got;
    int n;
    logic [31:0] c[2] = '{32'h200, 32'h203};
    pick <= 2'h3;  // noise lands on the selected pin
    wr(letc_pkg::ADDR_LINEPER, 32'd100);
    // trigger on holds the line timer at the new period; else the old count runs out first
    wr(letc_pkg::ADDR_CTRL, 32'h1);
    foreach (c[i]) begin
      wr(letc_pkg::ADDR_CTRL, c[i]);
      wait_pulse(300, got, n);
      wait_pulse(300, got, n);
      chk("line period", 100, n);
    end
    $display("test_internal done");
  endtask : test_internal
  task trig_case(input logic [2:0] org, input logic [2:0] act, input logic [1:0] pk, input logic idle,
                 input logic expect_hit);
    logic got;
    int n;
    wr(letc_pkg::ADDR_CTRL, 32'h1);
    pick <= pk;
    lvl <= idle;
    repeat (60) @(posedge pclk);
    wr(letc_pkg::ADDR_CTRL, 32'h1 | {21'h0, org, 1'b0, act, 4'h0});
    wait_pulse(12, got, n);
    chk("quiet", 0, got);
    act_cnt = 0;
    beg_cnt = 0;
    lvl <= ~idle;
    wait_pulse(12, got, n);
    lvl <= idle;
    chk("fire", expect_hit, got);
    repeat (60) @(posedge pclk);
    chk("lines", expect_hit, beg_cnt);
    chk("exp len", expect_hit ? EXP_CYC : 0, act_cnt);
  endtask : trig_case
  task test_act;
    logic [2:0] a[5] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h4};
    logic idl[5] = '{1'b0, 1'b1, 1'b1, 1'b0, 1'b1};
    foreach (a[i]) trig_case(3'h2, a[i], 2'h1, idl[i], 1'b1);
    trig_case(3'h2, 3'h2, 2'h1, 1'b0, 1'b1);
    $display("test_act done");
  endtask : test_act
  task test_origin;
    for (int p = 0; p < 4; p++) trig_case(3'(p + 1), 3'h0, 2'(p), 1'b0, 1'b1);
    trig_case(3'h0, 3'h0, 2'h1, 1'b0, 1'b0);
    $display("test_origin done");
  endtask : test_origin
  task test_width;
    logic [31:0] q;
    logic e;
    wr(letc_pkg::ADDR_CTRL, 32'h1);
    pick <= 2'h2;
    lvl <= 0;
    repeat (60) @(posedge pclk);
    wr(letc_pkg::ADDR_CTRL, 32'h305);
    @(posedge pclk);
    act_cnt = 0;
    lvl <= 1;
    repeat (20) @(posedge pclk);
    apb(0, letc_pkg::ADDR_STATUS, 0, q, e);
    chk("width status", 32'ha, q);
    repeat (7) @(posedge pclk);
    lvl <= 0;
    repeat (20) @(posedge pclk);
    chk("width len", 1, act_cnt >= 29 && act_cnt <= 31);
    $display("test_width done");
  endtask : test_width
  task end_sim;
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : end_sim
  initial begin
    #(50 * 40000);
    fail_count++;
    end_sim;
  end
  initial begin
    presetn = 0; psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0; pick = 0; lvl = 0;
    repeat (4) @(posedge pclk);
    presetn <= 1;
    test_regs;
    test_internal;
    test_act;
    test_origin;
    test_width;
    end_sim;
  end
endmodule : testbench
`default_nettype wire
